// ### common/oag_pkg.sv
package oag_pkg;
   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int OAG_RSEL_W = 4;
   localparam int OAG_TSEL_W = 4;
   localparam int OAG_DISP_W = 16;
   localparam int OAG_ADDR_W = 24;
   localparam int OAG_WORD_W = 32;
   localparam int OAG_HALF_W = 16;
   localparam int OAG_VP_W = 3;
   localparam int OAG_CRSUM_W = 8;
   localparam int OAG_VPR_WORDS = 4;
   localparam int OAG_CR_WORDS = 64;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int OAG_T_IND_BIT = 3;
   localparam int OAG_CR_WORD_LSB = 2;
   // ----------------------------------------------------------------
   // apb register byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] OAG_A_CTRL = 8'h00;
   localparam logic [7:0] OAG_A_INSTR = 8'h04;
   localparam logic [7:0] OAG_A_BASE = 8'h08;
   localparam logic [7:0] OAG_A_PC = 8'h0c;
   localparam logic [7:0] OAG_A_CELL = 8'h10;
   localparam logic [7:0] OAG_A_VPR0 = 8'h20;
   localparam logic [7:0] OAG_A_EA = 8'h30;
   localparam logic [7:0] OAG_A_IMM = 8'h34;
   localparam logic [7:0] OAG_A_SEL = 8'h38;
   localparam logic [7:0] OAG_A_STAT = 8'h3c;
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] OAG_RST_WORD = 32'h0000_0000;
   localparam logic [31:0] OAG_BAD_ADDR_DATA = 32'h0000_0000;
   // ----------------------------------------------------------------
   // operand type selected by the opcode
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      OAG_OP_IMM,
      OAG_OP_CM,
      OAG_OP_ABS,
      OAG_OP_PCREL,
      OAG_OP_REG_VPR,
      OAG_OP_REG_CR
   } oag_optype_t;
endpackage

// ### hw/oag_reg_select.sv
`timescale 1ns/1ps
// decodes a register selector into word, halfword and byte positions
module oag_reg_select
   import oag_pkg::*;
(
   input wire logic [7:0] sel,
   input wire logic is_cr,
   input wire logic [7:0] vpr3_byte3,
   output logic [5:0] word_idx,
   output logic half_left,
   output logic [1:0] byte_idx
);
   logic [7:0] cr_sum;
   // comm_register selector offset by byte 3 of register 3, carry dropped
   assign cr_sum = 8'(sel + vpr3_byte3); // see [RULE_02]
   // vp_register: two high bits of the 4-bit field are the word
   assign word_idx = is_cr ? cr_sum[7:2] : {4'h0, sel[3:2]}; // see [RULE_01]
   assign half_left = is_cr ? cr_sum[1] : sel[1]; // see [RULE_01]
   assign byte_idx = is_cr ? cr_sum[1:0] : sel[1:0]; // see [RULE_02]
endmodule

// ### hw/oag_top.sv
`timescale 1ns/1ps
// Function
// [RULE_01] R field: word, halfword, byte of register
// [RULE_02] comm_register select adds register 3 byte 3
// [RULE_03] T top bit indirect, low three index
// [RULE_04] index code 000 means no indexing
// [RULE_05] opcode chooses displacement meaning
// [RULE_06] displacement low 4 or 8 bits select register
// [RULE_07] immediate: sign-extend both to 32, add
// [RULE_08] memory address: disp plus base plus index
// [RULE_09] absolute: disp plus index, no base
// [RULE_10] pc relative: sext disp plus pc plus index
// [RULE_11] indirect cell: address field plus index
// [RULE_12] augmented: low three bits become vp code
// [RULE_13] augment only first indirect level
// [RULE_14] operand type from index, displacement, opcode; the code takes it from ctrl[2:0] only
// [RULE_15] address sums truncate to 24 bits silently
module oag_top
   import oag_pkg::*;
#(
   parameter int VP_CODE_W = OAG_VP_W
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   // ctrl: [2:0] operand type, [3] augmented, [4] start, [5] cell step,
   // [10:8] active virtual_processor code
   logic [31:0] ctrl;
   logic [31:0] instr; // [3:0] R, [7:4] T, [31:16] N
   logic [23:0] base_reg;
   logic [23:0] pc_reg;
   logic [23:0] cell_addr;
   logic [31:0] vp_register [OAG_VPR_WORDS];
   logic [23:0] ea;
   logic [31:0] imm;
   logic [31:0] sel_out; // [5:0] word, [6] left half, [9:8] byte; R at 16+
   logic indirect_pend;
   logic first_level;
   logic [31:0] next_prdata;

   // ----------------------------------------------------------------
   // field decode
   // ----------------------------------------------------------------
   logic [3:0] r_fld;
   logic [3:0] t_fld;
   logic [15:0] n_fld;
   logic t_indirect;
   logic [2:0] t_idx;
   logic index_on;
   logic [15:0] idx_half;
   logic [31:0] idx_word;
   oag_optype_t op_type;
   logic augmented;
   logic [VP_CODE_W-1:0] vp_code;
   logic [31:0] ctrl_now;

   assign r_fld = instr[3:0];
   assign t_fld = instr[7:4];
   assign n_fld = instr[31:16];
   assign t_indirect = t_fld[OAG_T_IND_BIT]; // see [RULE_03]
   assign t_idx = t_fld[2:0]; // see [RULE_03]
   assign index_on = (t_idx != 3'h0); // see [RULE_04]
   assign idx_word = vp_register[t_idx[2:1]];
   // code 1 is right half of register 0, odd codes right, even left
   assign idx_half = t_idx[0] ? idx_word[15:0] : idx_word[31:16]; // see [RULE_04]
   assign op_type = oag_optype_t'(ctrl_now[2:0]); // see [RULE_05]
   assign augmented = ctrl_now[3];
   assign vp_code = ctrl_now[8 +: VP_CODE_W];

   // ----------------------------------------------------------------
   // sums
   // ----------------------------------------------------------------
   logic [31:0] t32;
   logic [23:0] t24;
   logic [31:0] imm_sum;
   logic [23:0] cm_sum;
   logic [23:0] abs_sum;
   logic [23:0] pcr_sum;
   logic [23:0] cell_sum;
   logic [23:0] dev_ea;
   logic [23:0] aug_ea;
   logic aug_now;

   assign t32 = index_on ? {{16{idx_half[15]}}, idx_half} : 32'h0000_0000; // see [RULE_07]
   assign t24 = t32[23:0];
   assign imm_sum = 32'({{16{n_fld[15]}}, n_fld} + t32); // see [RULE_07]
   // carries beyond 24 bits are dropped without any flag
   assign cm_sum = 24'({8'h00, n_fld} + base_reg + t24); // see [RULE_08] [RULE_15]
   assign abs_sum = 24'({8'h00, n_fld} + t24); // see [RULE_09] [RULE_15]
   assign pcr_sum = 24'({{8{n_fld[15]}}, n_fld} + pc_reg + t24); // see [RULE_10] [RULE_15]
   assign cell_sum = 24'(cell_addr + t24); // see [RULE_11] [RULE_15]

   // operand type comes from the ctrl opcode field alone, not from the T and N fields
   assign dev_ea = (op_type == OAG_OP_CM) ? cm_sum :
                   (op_type == OAG_OP_PCREL) ? pcr_sum : abs_sum; // see [RULE_14]
   // augmenting applies to memory and absolute addresses and only the first level
   assign aug_now = augmented && first_level &&
                    (op_type == OAG_OP_CM || op_type == OAG_OP_ABS); // see [RULE_13]
   assign aug_ea = {dev_ea[23:VP_CODE_W], vp_code}; // see [RULE_12]

   // ----------------------------------------------------------------
   // register selection
   // ----------------------------------------------------------------
   logic sel_is_cr;
   logic [7:0] sel_src;
   logic [5:0] sel_word;
   logic sel_left;
   logic [1:0] sel_byte;

   assign sel_is_cr = (op_type == OAG_OP_REG_CR);
   // displacement plus index selects register using the low 4 or 8 bits of the sum
   assign sel_src = sel_is_cr ? abs_sum[7:0] : {4'h0, abs_sum[3:0]}; // see [RULE_06]

   oag_reg_select u_nsel
   (
      .sel(sel_src),
      .is_cr(sel_is_cr),
      .vpr3_byte3(vp_register[3][31:24]),
      .word_idx(sel_word),
      .half_left(sel_left),
      .byte_idx(sel_byte)
   );

   logic [5:0] rs_word;
   logic [1:0] rs_byte;

   oag_reg_select u_rsel
   (
      .sel({4'h0, r_fld}),
      .is_cr(ctrl_now[6]),
      .vpr3_byte3(vp_register[3][31:24]),
      .word_idx(rs_word),
      .half_left(),
      .byte_idx(rs_byte)
   );

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   logic wr_en;
   logic rd_en;
   logic start;
   logic cell_step;
   logic addr_ok;
   logic vpr_hit;

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;
   assign start = wr_en && (paddr == OAG_A_CTRL) && pwdata[4];
   assign cell_step = wr_en && (paddr == OAG_A_CTRL) && pwdata[5];
   // a start write decodes the fields that arrive with it, not the old ctrl
   assign ctrl_now = (wr_en && paddr == OAG_A_CTRL) ? pwdata : ctrl;
   assign vpr_hit = (paddr[7:4] == OAG_A_VPR0[7:4]) && (paddr[1:0] == 2'b00);
   assign addr_ok = (paddr == OAG_A_CTRL) || (paddr == OAG_A_INSTR) ||
                    (paddr == OAG_A_BASE) || (paddr == OAG_A_PC) ||
                    (paddr == OAG_A_CELL) || (paddr == OAG_A_EA) ||
                    (paddr == OAG_A_IMM) || (paddr == OAG_A_SEL) ||
                    (paddr == OAG_A_STAT) ||
                    vpr_hit;

   always_comb
   begin
      next_prdata = OAG_BAD_ADDR_DATA;
      if (vpr_hit)
      begin
         next_prdata = vp_register[paddr[3:2]];
      end
      else
      begin
         unique case (paddr)
            OAG_A_CTRL: next_prdata = ctrl;
            OAG_A_INSTR: next_prdata = instr;
            OAG_A_BASE: next_prdata = {8'h00, base_reg};
            OAG_A_PC: next_prdata = {8'h00, pc_reg};
            OAG_A_CELL: next_prdata = {8'h00, cell_addr};
            OAG_A_EA: next_prdata = {8'h00, ea};
            OAG_A_IMM: next_prdata = imm;
            OAG_A_SEL: next_prdata = sel_out;
            OAG_A_STAT: next_prdata = {29'h0, first_level, indirect_pend, index_on};
            default: next_prdata = OAG_BAD_ADDR_DATA;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // apb response: no wait states, data captured in setup
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= OAG_RST_WORD;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         if (rd_en)
         begin
            prdata <= next_prdata;
         end
         pready <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
      end
   end

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl <= OAG_RST_WORD;
         instr <= OAG_RST_WORD;
         base_reg <= OAG_RST_WORD[23:0];
         pc_reg <= OAG_RST_WORD[23:0];
         cell_addr <= OAG_RST_WORD[23:0];
         for (int i = 0; i < OAG_VPR_WORDS; i++)
         begin
            vp_register[i] <= OAG_RST_WORD;
         end
      end
      else if (wr_en)
      begin
         if (paddr == OAG_A_CTRL)
         begin
            ctrl <= {pwdata[31:6], 2'b00, pwdata[3:0]};
         end
         if (paddr == OAG_A_INSTR)
         begin
            instr <= pwdata;
         end
         if (paddr == OAG_A_BASE)
         begin
            base_reg <= pwdata[23:0];
         end
         if (paddr == OAG_A_PC)
         begin
            pc_reg <= pwdata[23:0];
         end
         if (paddr == OAG_A_CELL)
         begin
            cell_addr <= pwdata[23:0];
         end
         if (vpr_hit)
         begin
            vp_register[paddr[3:2]] <= pwdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // address development
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ea <= OAG_RST_WORD[23:0];
         imm <= OAG_RST_WORD;
         sel_out <= OAG_RST_WORD;
         indirect_pend <= 1'b0;
         first_level <= 1'b1;
      end
      else if (start)
      begin
         // start uses the ctrl fields that are written with it
         ea <= aug_now ? aug_ea : dev_ea; // see [RULE_12]
         imm <= imm_sum; // see [RULE_07]
         sel_out <= {6'h00, rs_byte, 2'b00, rs_word, 6'h00, sel_byte, 1'b0,
                     sel_left, sel_word}; // see [RULE_01] [RULE_06]
         indirect_pend <= t_indirect; // see [RULE_03]
         first_level <= 1'b0;
      end
      else if (cell_step && indirect_pend)
      begin
         // later indirect levels are never augmented
         ea <= cell_sum; // see [RULE_11] [RULE_13]
      end
      else if (wr_en && paddr == OAG_A_INSTR)
      begin
         first_level <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // checks on address development
   // ----------------------------------------------------------------
   sequence s_cell_step;
      cell_step && indirect_pend && !start;
   endsequence
   property p_imm_unindexed;
      @(posedge pclk) disable iff (!presetn)
         start && !index_on |=> $signed(imm) == $signed($past(n_fld));
   endproperty
   a_imm_unindexed: assert property (p_imm_unindexed) else $error("immediate wrong"); // see [RULE_07]
   property p_abs_plain;
      @(posedge pclk) disable iff (!presetn)
         start && !index_on && !augmented && op_type == OAG_OP_ABS
         |=> ea == {8'h00, $past(n_fld)};
   endproperty
   a_abs_plain: assert property (p_abs_plain) else $error("absolute address wrong"); // see [RULE_09]
   property p_pcrel_plain;
      @(posedge pclk) disable iff (!presetn)
         start && !index_on && op_type == OAG_OP_PCREL
         |=> ea == 24'($signed($past(pc_reg)) + $signed($past(n_fld)));
   endproperty
   a_pcrel_plain: assert property (p_pcrel_plain) else $error("pc relative wrong"); // see [RULE_10]
   property p_aug_code;
      @(posedge pclk) disable iff (!presetn)
         start && augmented && first_level && op_type == OAG_OP_CM
         |=> ea[VP_CODE_W-1:0] == $past(vp_code);
   endproperty
   a_aug_code: assert property (p_aug_code) else $error("augment code missing"); // see [RULE_12]
   property p_first_cleared;
      @(posedge pclk) disable iff (!presetn) start |=> !first_level;
   endproperty
   a_first_cleared: assert property (p_first_cleared) else $error("first level kept"); // see [RULE_13]
   property p_cell_level;
      @(posedge pclk) disable iff (!presetn) s_cell_step |=> ea == 24'($past(cell_addr) + $past(t24));
   endproperty
   a_cell_level: assert property (p_cell_level) else $error("cell step wrong"); // see [RULE_11] [RULE_13]
endmodule

// ### test/oag_apb_partner.sv
`timescale 1ns/1ps
// ----------------
// apb master standing in for the control sequencer
// ----------------
module oag_apb_partner
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic go,
   input wire logic wr,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   output logic done,
   output logic [31:0] rdata,
   output logic err
);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         psel <= 1'b0;
         penable <= 1'b0;
         pwrite <= 1'b0;
         paddr <= 8'h00;
         pwdata <= 32'h0000_0000;
         done <= 1'b0;
         rdata <= 32'h0000_0000;
         err <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (psel && penable && pready)
         begin
            psel <= 1'b0;
            penable <= 1'b0;
            done <= 1'b1;
            rdata <= prdata;
            err <= pslverr;
            // released lines no longer show the last value
            paddr <= ~paddr;
            pwdata <= ~pwdata;
         end
         else if (psel)
            penable <= 1'b1;
         else if (go)
         begin
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= addr;
            pwdata <= wdata;
         end
      end
   end
endmodule

// ### test/oag_top_tb_top.sv
`timescale 1ns/1ps
module oag_top_tb_top
   import oag_pkg::*;
;
   typedef struct packed {oag_optype_t op; logic aug; logic [2:0] vp; logic [3:0] t;
      logic [15:0] n; logic [31:0] want;} oag_row_t;
   localparam logic [23:0] BASE = 24'hfff0f0;
   localparam logic [23:0] PC = 24'h000100;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic go = 1'b0;
   logic wr = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic psel, penable, pwrite, pready, pslverr, done, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   int n_mismatch = 0;
   int checks_done = 0;
   logic [31:0] vp_register [4] = '{32'h0003_fff0, 32'h8000_0004, 32'h1111_2222, 32'h05ff_0010};
   oag_row_t rows [9] = '{
      '{OAG_OP_IMM, 1'b0, 3'h0, 4'h0, 16'h7fff, 32'h0000_7fff},
      '{OAG_OP_IMM, 1'b0, 3'h0, 4'h1, 16'h8000, 32'hffff_7ff0},
      '{OAG_OP_IMM, 1'b0, 3'h0, 4'h8, 16'h0001, 32'h0000_0001},
      '{OAG_OP_CM, 1'b0, 3'h0, 4'h2, 16'h0030, 32'h00ff_7120},
      '{OAG_OP_CM, 1'b1, 3'h5, 4'h0, 16'h1234, 32'h0000_0325},
      '{OAG_OP_ABS, 1'b0, 3'h0, 4'h7, 16'hffff, 32'h0001_000f},
      '{OAG_OP_ABS, 1'b1, 3'h2, 4'h3, 16'h0008, 32'h0000_000a},
      '{OAG_OP_PCREL, 1'b0, 3'h0, 4'h3, 16'hff00, 32'h0000_0004},
      '{OAG_OP_PCREL, 1'b1, 3'h6, 4'h0, 16'h0004, 32'h0000_0104}};

   oag_top i_oag_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   oag_apb_partner i_oag_apb_partner (.pclk(pclk), .presetn(presetn), .go(go), .wr(wr),
      .addr(addr), .wdata(wdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .done(done), .rdata(rdata), .err(err));

   initial
   begin
      forever #2.5 pclk = ~pclk;
   end

   // ----------------
   // bus access and comparisons
   // ----------------
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      go <= 1'b1;
      wr <= w;
      addr <= a;
      wdata <= d;
      @(posedge pclk);
      go <= 1'b0;
      while (done !== 1'b1)
      begin
         @(posedge pclk);
         #1;
      end
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_flag(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask

   task automatic run(input logic [31:0] ins, input logic [31:0] ctl, input logic [7:0] ra,
      input logic [31:0] m, input logic [31:0] e);
      bus(1'b1, OAG_A_INSTR, ins);
      bus(1'b1, OAG_A_CTRL, ctl);
      bus(1'b0, ra, 32'h0);
      chk(rdata & m, e);
   endtask

   task automatic run_row(input oag_row_t r);
      bus(1'b1, OAG_A_INSTR, {r.n, 8'h00, r.t, 4'h0});
      bus(1'b1, OAG_A_CTRL, {21'h0, r.vp, 4'b0001, r.aug, r.op});
      bus(1'b0, (r.op == OAG_OP_IMM) ? OAG_A_IMM : OAG_A_EA, 32'h0);
      chk(rdata, r.want);
      bus(1'b0, OAG_A_STAT, 32'h0);
      chk(rdata & 32'h7, {30'h0, r.t[3], r.t[2:0] != 3'b000});
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ----------------
   // tests
   // ----------------
   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      bus(1'b0, OAG_A_CTRL, 32'h0);
      chk(rdata, OAG_RST_WORD);
      bus(1'b0, OAG_A_EA, 32'h0);
      chk(rdata, OAG_RST_WORD);
      $display("test reset done");
      for (int k = 0; k < 4; k++)
         bus(1'b1, OAG_A_VPR0 + 8'(4 * k), vp_register[k]);
      bus(1'b1, OAG_A_BASE, {8'h00, BASE});
      bus(1'b1, OAG_A_PC, {8'h00, PC});
      foreach (rows[i])
         run_row(rows[i]);
      $display("test table done");
      run(32'h0000_000d, 32'h0000_0012, OAG_A_SEL, 32'h033f_0000, 32'h0103_0000);
      run(32'h0000_0006, 32'h0000_0052, OAG_A_SEL, 32'h033f_0000, 32'h0302_0000);
      run(32'h0007_0000, 32'h0000_0014, OAG_A_SEL, 32'h0000_037f, 32'h0000_0341);
      $display("test select done");
      run(32'h0040_0090, 32'h0000_0519, OAG_A_EA, 32'hffff_ffff, 32'h00ff_f125);
      bus(1'b0, OAG_A_STAT, 32'h0);
      chk(rdata & 32'h7, 32'h0000_0003);
      bus(1'b1, OAG_A_CELL, 32'h0000_0023);
      bus(1'b1, OAG_A_CTRL, 32'h0000_0529);
      bus(1'b0, OAG_A_EA, 32'h0);
      chk(rdata, 32'h0000_0013);
      $display("test indirect done");
      bus(1'b0, 8'h14, 32'h0);
      chk_flag(err, 1'b1);
      chk(rdata, OAG_BAD_ADDR_DATA);
      $display("test unmapped done");
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      bus(1'b0, OAG_A_EA, 32'h0);
      chk(rdata, OAG_RST_WORD);
      bus(1'b0, OAG_A_VPR0, 32'h0);
      chk(rdata, OAG_RST_WORD);
      bus(1'b0, OAG_A_STAT, 32'h0);
      chk(rdata, 32'h0000_0004);
      $display("test mid reset done");
      tally_and_finish;
   end

   initial
   begin
      #100000;
      n_mismatch++;
      tally_and_finish;
   end
endmodule
